// File: lbc_pkg.sv
// shared constants for the lane b configuration register
package lbc_pkg;
	// register bus geometry
	localparam int          LBC_AW          = 8;
	localparam int          LBC_DW          = 16;
	// register offset as printed
	localparam logic [7:0]  LBC_CFG_OFS     = 8'h12;
	// reset value: loss-of-signal and alignment enabled
	localparam logic [15:0] LBC_CFG_RST     = 16'h0102;
	// mask of the bits that hold storage
	localparam logic [15:0] LBC_CFG_MASK    = 16'h0FFF;
	// field positions
	localparam int          LBC_B_CTC       = 11;
	localparam int          LBC_B_MF_HI     = 10;
	localparam int          LBC_B_MF_LO     = 9;
	localparam int          LBC_B_LOS       = 8;
	localparam int          LBC_B_CFG_HI    = 7;
	localparam int          LBC_B_CFG_LO    = 6;
	localparam int          LBC_B_EMPH_HI   = 5;
	localparam int          LBC_B_EMPH_LO   = 4;
	localparam int          LBC_B_LOOP      = 3;
	localparam int          LBC_B_PAT       = 2;
	localparam int          LBC_B_ALIGN     = 1;
	localparam int          LBC_B_PDN       = 0;
	// bits of the device control register used here
	localparam int          LBC_CTL_LOOP    = 14;
	localparam int          LBC_CTL_PDN     = 11;
	// multifunction pin source codes
	typedef enum logic [1:0] {
		LBC_MF_IOSTD   = 2'h0,
		LBC_MF_COMMA   = 2'h1,
		LBC_MF_LOS     = 2'h2,
		LBC_MF_PATPASS = 2'h3
	} lbc_mf_e;
endpackage : lbc_pkg

// File: lbc_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser for pins from outside the clock domain
module lbc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	// asynchronous inputs
	input  wire logic [W-1:0] async_in,
	// synchronised outputs
	output logic      [W-1:0] sync_out
);
	// first stage, read only by the second stage
	logic [W-1:0] meta_r;

	// both stages clear on reset
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : lbc_sync

// File: lbc_lane_cfg.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
// What this block does
// - bits 15:12 read zero, writes dropped
// - clock compensation = lane bit11 OR global
// - select code picks multifunction pin source
// - select code = lane field OR global
// - loss detect = lane bit8 AND global
// - bit7 writable only while high strap low
// - bit6 writable only while low strap low
// - emphasis bits OR global, reset zero
// - loopback = lane bit3 OR control bit14
// - pattern test ORed, read-only while pin high
// - alignment = lane bit1 AND pin AND global
// - power down = lane bit0 OR control bit11
module lbc_lane_cfg
	import lbc_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// register port
	input  wire logic [LBC_AW-1:0] reg_addr,
	input  wire logic [LBC_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [LBC_DW-1:0] reg_rdata,
	// global lane register and device control register
	input  wire logic [LBC_DW-1:0] glb_cfg,
	input  wire logic [LBC_DW-1:0] dev_ctl,
	// device pins
	input  wire logic              interface_strap_hi,
	input  wire logic              interface_strap_lo,
	input  wire logic              pattern_test_pin,
	input  wire logic              align_enable_pin,
	input  wire logic              io_std_hstl,
	// lane status from the receive path
	input  wire logic              comma_detected,
	input  wire logic              lane_los,
	input  wire logic              pattern_pass,
	// effective lane controls
	output logic                   ctc_en,
	output logic                   lane_b_multifunction_pin,
	output logic                   los_det_en,
	output logic                   iface_cfg_hi,
	output logic                   iface_cfg_lo,
	output logic                   emphasis_ctrl_hi,
	output logic                   emphasis_ctrl_lo,
	output logic                   loopback_en,
	output logic                   pattern_en,
	output logic                   align_en,
	output logic                   power_down
);
	// synchronised pins
	logic [4:0]        pins_s;
	logic              strap_hi_s;  // high strap
	logic              strap_lo_s;  // low strap
	logic              pat_pin_s;   // pattern test pin
	logic              align_pin_s; // alignment enable pin
	logic              hstl_s;      // io standard indication

	// stored configuration and its next value
	logic [LBC_DW-1:0] cfg_r;
	logic [LBC_DW-1:0] cfg_nxt;

	// decode
	logic              hit;
	logic              wr_hit;
	logic              rd_hit;
	logic [LBC_DW-1:0] wr_mask;
	logic [LBC_DW-1:0] rd_nxt;

	// effective values
	logic [1:0]        mf_sel;
	logic              mf_nxt;

	// single bit at a field position, used to punch frozen bits out of the write mask
	function automatic logic [LBC_DW-1:0] bit_at(input logic en, input int pos);
		return LBC_DW'(en) << pos;
	endfunction : bit_at

	// pins cross into the clock domain first
	lbc_sync #(
		.W        (5)
	) u_sync (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.async_in ({interface_strap_hi, interface_strap_lo,
		            pattern_test_pin, align_enable_pin, io_std_hstl}),
		.sync_out (pins_s)
	);

	assign strap_hi_s  = pins_s[4];
	assign strap_lo_s  = pins_s[3];
	assign pat_pin_s   = pins_s[2];
	assign align_pin_s = pins_s[1];
	assign hstl_s      = pins_s[0];

	// address decode
	assign hit    = (reg_addr == LBC_CFG_OFS);
	assign wr_hit = hit & reg_wr;
	assign rd_hit = hit & reg_rd;

	// writable bits: storage bits less the ones frozen by a high pin
	assign wr_mask = LBC_CFG_MASK
	               & ~bit_at(strap_hi_s, LBC_B_CFG_HI)
	               & ~bit_at(strap_lo_s, LBC_B_CFG_LO)
	               & ~bit_at(pat_pin_s,  LBC_B_PAT);

	// merge written bits with held ones
	assign cfg_nxt = wr_hit ? ((reg_wdata & wr_mask) | (cfg_r & ~wr_mask))
	                        : cfg_r;

	// read data, zero above bit 11 and for unmapped addresses
	assign rd_nxt = rd_hit ? (cfg_r & LBC_CFG_MASK) : '0;

	// effective multifunction select
	assign mf_sel = cfg_r[LBC_B_MF_HI:LBC_B_MF_LO]
	              | glb_cfg[LBC_B_MF_HI:LBC_B_MF_LO];

	// multifunction pin source
	always_comb begin
		unique case (lbc_mf_e'(mf_sel))
			LBC_MF_IOSTD:   mf_nxt = hstl_s;
			LBC_MF_COMMA:   mf_nxt = comma_detected;
			LBC_MF_LOS:     mf_nxt = lane_los;
			LBC_MF_PATPASS: mf_nxt = pattern_pass;
		endcase
	end

	// configuration storage
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_r <= LBC_CFG_RST;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// read data stands one cycle after the strobe
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= rd_nxt;
		end
	end

	// effective controls, registered
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctc_en                   <= 1'b0;
			lane_b_multifunction_pin <= 1'b0;
			los_det_en               <= 1'b0;
			iface_cfg_hi             <= 1'b0;
			iface_cfg_lo             <= 1'b0;
			emphasis_ctrl_hi         <= 1'b0;
			emphasis_ctrl_lo         <= 1'b0;
			loopback_en              <= 1'b0;
			pattern_en               <= 1'b0;
			align_en                 <= 1'b0;
			power_down               <= 1'b0;
		end else begin
			ctc_en                   <= cfg_r[LBC_B_CTC] | glb_cfg[LBC_B_CTC];
			lane_b_multifunction_pin <= mf_nxt;
			los_det_en               <= cfg_r[LBC_B_LOS] & glb_cfg[LBC_B_LOS];
			iface_cfg_hi             <= cfg_r[LBC_B_CFG_HI] | glb_cfg[LBC_B_CFG_HI];
			iface_cfg_lo             <= cfg_r[LBC_B_CFG_LO] | glb_cfg[LBC_B_CFG_LO];
			emphasis_ctrl_hi         <= cfg_r[LBC_B_EMPH_HI] | glb_cfg[LBC_B_EMPH_HI];
			emphasis_ctrl_lo         <= cfg_r[LBC_B_EMPH_LO] | glb_cfg[LBC_B_EMPH_LO];
			loopback_en              <= cfg_r[LBC_B_LOOP] | dev_ctl[LBC_CTL_LOOP];
			pattern_en               <= cfg_r[LBC_B_PAT] | glb_cfg[LBC_B_PAT];
			align_en                 <= cfg_r[LBC_B_ALIGN] & align_pin_s
			                          & glb_cfg[LBC_B_ALIGN];
			power_down               <= cfg_r[LBC_B_PDN] | dev_ctl[LBC_CTL_PDN];
		end
	end

	// checks on the register and its effective outputs
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// top nibble reads back zero on every read of the register
	property p_rsvd_zero;
		rd_hit |=> reg_rdata[15:12] == 4'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

	// a read returns the stored bits in the following cycle
	property p_rd_data;
		rd_hit |=> reg_rdata == {4'h0, $past(cfg_r[11:0])};
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data wrong");

	// a write never lands in the top nibble
	property p_wr_rsvd;
		wr_hit |=> cfg_r[15:12] == 4'h0;
	endproperty
	a_wr_rsvd: assert property (p_wr_rsvd) else $error("reserved bits stored");

	// compensation follows the or of both sources
	property p_ctc;
		!sys_rst |=> ctc_en == $past(cfg_r[LBC_B_CTC] | glb_cfg[LBC_B_CTC]);
	endproperty
	a_ctc: assert property (p_ctc) else $error("clock compensation wrong");

	// compensation bit takes whatever is written
	property p_ctc_wr;
		wr_hit |=> cfg_r[LBC_B_CTC] == $past(reg_wdata[LBC_B_CTC]);
	endproperty
	a_ctc_wr: assert property (p_ctc_wr) else $error("compensation bit not written");

	// both select codes zero gives io standard on the pin
	property p_mf_iostd;
		(!sys_rst && cfg_r[10:9] == 2'h0 && glb_cfg[10:9] == 2'h0) |=> lane_b_multifunction_pin == $past(hstl_s);
	endproperty
	a_mf_iostd: assert property (p_mf_iostd) else $error("pin not io standard");

	// select code one puts the comma flag on the pin
	property p_mf_comma;
		(!sys_rst && mf_sel == 2'h1) |=> lane_b_multifunction_pin == $past(comma_detected);
	endproperty
	a_mf_comma: assert property (p_mf_comma) else $error("pin not comma flag");

	// select code two puts loss of signal on the pin
	property p_mf_los;
		(!sys_rst && mf_sel == 2'h2) |=> lane_b_multifunction_pin == $past(lane_los);
	endproperty
	a_mf_los: assert property (p_mf_los) else $error("pin not loss of signal");

	// a global code of three forces pattern pass whatever the lane field
	property p_mf_or;
		(!sys_rst && glb_cfg[10:9] == 2'h3) |=> lane_b_multifunction_pin == $past(pattern_pass);
	endproperty
	a_mf_or: assert property (p_mf_or) else $error("select code not ored");

	// loss detect needs both bits
	property p_los;
		!sys_rst |=> los_det_en == $past(cfg_r[LBC_B_LOS] && glb_cfg[LBC_B_LOS]);
	endproperty
	a_los: assert property (p_los) else $error("loss detect enable wrong");

	// high strap freezes bit 7 across a write
	property p_cfg_hi_ro;
		(wr_hit && strap_hi_s) |=> $stable(cfg_r[LBC_B_CFG_HI]);
	endproperty
	a_cfg_hi_ro: assert property (p_cfg_hi_ro) else $error("bit 7 written while strapped");

	// high strap low lets a write land in bit 7
	property p_cfg_hi_wr;
		(wr_hit && !strap_hi_s) |=> cfg_r[LBC_B_CFG_HI] == $past(reg_wdata[LBC_B_CFG_HI]);
	endproperty
	a_cfg_hi_wr: assert property (p_cfg_hi_wr) else $error("bit 7 write lost");

	// low strap low lets a write land in bit 6, then it shows on the output
	property p_cfg_lo_wr;
		(wr_hit && !strap_lo_s) |=> cfg_r[LBC_B_CFG_LO] == $past(reg_wdata[LBC_B_CFG_LO])
		                        ##1 iface_cfg_lo == ($past(cfg_r[LBC_B_CFG_LO]) | $past(glb_cfg[LBC_B_CFG_LO]));
	endproperty
	a_cfg_lo_wr: assert property (p_cfg_lo_wr) else $error("bit 6 write or output wrong");

	// low strap high freezes bit 6 across a write
	property p_cfg_lo_ro;
		(wr_hit && strap_lo_s) |=> $stable(cfg_r[LBC_B_CFG_LO]);
	endproperty
	a_cfg_lo_ro: assert property (p_cfg_lo_ro) else $error("bit 6 written while strapped");

	// emphasis pair ors with the global pair
	property p_emph;
		!sys_rst |=> {emphasis_ctrl_hi, emphasis_ctrl_lo} == $past(cfg_r[5:4] | glb_cfg[5:4]);
	endproperty
	a_emph: assert property (p_emph) else $error("emphasis wrong");

	// loopback from the control register alone
	property p_loop;
		(!sys_rst && dev_ctl[LBC_CTL_LOOP]) |=> loopback_en;
	endproperty
	a_loop: assert property (p_loop) else $error("loopback not forced");

	// loopback off when neither source asks
	property p_loop_off;
		(!sys_rst && !cfg_r[LBC_B_LOOP] && !dev_ctl[LBC_CTL_LOOP]) |=> !loopback_en;
	endproperty
	a_loop_off: assert property (p_loop_off) else $error("loopback on unasked");

	// pattern pin high keeps bit 2 across a write, then the output follows the or of both bits
	property p_pat_ro;
		(wr_hit && pat_pin_s) |=> $stable(cfg_r[LBC_B_PAT])
		                      ##1 pattern_en == $past(cfg_r[LBC_B_PAT] | glb_cfg[LBC_B_PAT]);
	endproperty
	a_pat_ro: assert property (p_pat_ro) else $error("pattern bit not read-only");

	// pattern pin low lets a write land in bit 2
	property p_pat_wr;
		(wr_hit && !pat_pin_s) |=> cfg_r[LBC_B_PAT] == $past(reg_wdata[LBC_B_PAT]);
	endproperty
	a_pat_wr: assert property (p_pat_wr) else $error("pattern bit write lost");

	// alignment off if the pin is low
	property p_align;
		!align_pin_s |=> !align_en;
	endproperty
	a_align: assert property (p_align) else $error("alignment on with pin low");

	// alignment on when lane bit, pin and global bit all agree
	property p_align_on;
		(!sys_rst && cfg_r[LBC_B_ALIGN] && align_pin_s && glb_cfg[LBC_B_ALIGN]) |=> align_en;
	endproperty
	a_align_on: assert property (p_align_on) else $error("alignment off with all enables");

	// power down when either source asks
	property p_pdn;
		(!sys_rst && (cfg_r[LBC_B_PDN] || dev_ctl[LBC_CTL_PDN])) |=> power_down;
	endproperty
	a_pdn: assert property (p_pdn) else $error("power down missing");

endmodule : lbc_lane_cfg

// File: lbc_lane_cfg_test.sv
`timescale 1ns/1ns
// self-checking bench for the lane b configuration register
module lbc_lane_cfg_test
	import lbc_pkg::*;
;
	// clock, reset and register port
	logic              mclk      = 1'b0;
	logic              sys_rst   = 1'b1;
	logic [LBC_AW-1:0] reg_addr  = '0;
	logic [LBC_DW-1:0] reg_wdata = '0;
	logic              reg_wr    = 1'b0;
	logic              reg_rd    = 1'b0;
	logic [LBC_DW-1:0] reg_rdata;
	// global bits, pins and lane status
	logic [LBC_DW-1:0] glb_cfg = '0, dev_ctl = '0;
	logic              strap_hi = 1'b0, strap_lo = 1'b0, pat_pin = 1'b0, aln_pin = 1'b0, hstl = 1'b0;
	logic              comma = 1'b0, los = 1'b0, ppass = 1'b0;
	// effective controls
	logic              ctc_en, mf_pin, los_det_en, cfg_hi, cfg_lo, emph_hi, emph_lo;
	logic              loopback_en, pattern_en, align_en, power_down;
	// bench state
	int                fails = 0, cmp_count = 0, cyc = 0;
	integer            seed = 32'h07C3;
	logic [15:0]       model, d, w;

	lbc_lane_cfg lbc_lane_cfg_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .glb_cfg(glb_cfg), .dev_ctl(dev_ctl),
		.interface_strap_hi(strap_hi), .interface_strap_lo(strap_lo), .pattern_test_pin(pat_pin),
		.align_enable_pin(aln_pin), .io_std_hstl(hstl), .comma_detected(comma), .lane_los(los),
		.pattern_pass(ppass), .ctc_en(ctc_en), .lane_b_multifunction_pin(mf_pin), .los_det_en(los_det_en),
		.iface_cfg_hi(cfg_hi), .iface_cfg_lo(cfg_lo), .emphasis_ctrl_hi(emph_hi), .emphasis_ctrl_lo(emph_lo),
		.loopback_en(loopback_en), .pattern_en(pattern_en), .align_en(align_en), .power_down(power_down));

	// 100 ns clock
	initial begin
		forever #50 mclk = ~mclk;
	end

	// hang guard: far above the expected run length
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails = fails + 1;
			close_out();
		end
	end

	// next register value after a write, frozen bits kept
	function automatic logic [15:0] nxt_cfg(input logic [15:0] old, input logic [15:0] wd);
		logic [15:0] n;
		n = {4'h0, wd[11:0]};
		if (strap_hi) n[7] = old[7];
		if (strap_lo) n[6] = old[6];
		if (pat_pin) n[2] = old[2];
		return n;
	endfunction : nxt_cfg

	// expected effective controls for a register value
	function automatic logic [10:0] exp_out(input logic [15:0] c);
		logic [1:0] s;
		logic       m;
		s = c[10:9] | glb_cfg[10:9];
		m = (s == 2'h0) ? hstl : (s == 2'h1) ? comma : (s == 2'h2) ? los : ppass;
		return {c[11] | glb_cfg[11], m, c[8] & glb_cfg[8], c[7:4] | glb_cfg[7:4], c[3] | dev_ctl[14],
			c[2] | glb_cfg[2], c[1] & aln_pin & glb_cfg[1], c[0] | dev_ctl[11]};
	endfunction : exp_out

	// one compare task per kind of result
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk16

	task automatic chk_out(input logic [15:0] c);
		logic [10:0] got;
		got = {ctc_en, mf_pin, los_det_en, cfg_hi, cfg_lo, emph_hi, emph_lo, loopback_en, pattern_en,
			align_en, power_down};
		cmp_count = cmp_count + 1;
		if (got !== exp_out(c)) begin
			fails = fails + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp_out(c));
		end
	endtask : chk_out

	// register bus cycles
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		v = reg_rdata;
	endtask : bus_rd

	// reset, read back defaults and check outputs
	task automatic reset_check();
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		bus_rd(8'h12, d);
		chk16(d, 16'h0102);
		model = 16'h0102;
		repeat (3) @(negedge mclk);
		chk_out(model);
		$display("reset test ended, checks %0d", cmp_count);
	endtask : reset_check

	// verdict and end of run
	task automatic close_out();
		$display("checks %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	// main sequence
	initial begin
		reset_check();
		for (int i = 0; i < 120; i++) begin
			@(posedge mclk);
			glb_cfg <= (i < 4) ? 16'h0000 : 16'($random(seed));
			dev_ctl <= 16'($random(seed));
			{strap_hi, strap_lo, pat_pin, aln_pin, hstl, comma, los, ppass} <= 8'($random(seed));
			repeat (4) @(posedge mclk);
			// corner cases first: all ones then all zeros, each select code
			w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : (i < 6) ? 16'(i - 2) << 9 : 16'($random(seed));
			if (i % 8 == 7) begin
				bus_wr(8'h13, w);
				bus_rd(8'h13, d);
				chk16(d, 16'h0000);
			end else begin
				bus_wr(8'h12, w);
				model = nxt_cfg(model, w);
			end
			bus_rd(8'h12, d);
			chk16(d, model);
			@(negedge mclk);
			chk_out(model);
		end
		$display("random test ended, checks %0d", cmp_count);
		reset_check();
		close_out();
	end
endmodule : lbc_lane_cfg_test
